// ==== logic/spr_top.sv ====
/*
 * Sleep control, brown-out sleep-off sequence, peripheral clock gating and
 * reset stretching. Assumes sources are synchronous to clk_sys except the
 * immediate (asynchronous) reset path, which is combined outside the flops.
 */
`timescale 1ns/1ns
module spr_top
   import spr_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYCLES
) (
   input  wire logic            clk_sys,
   input  wire logic            rst_b,
   input  wire spr_bus_type     bus,
   input  wire spr_rst_src_type src,
   input  wire logic            bod_enable,
   input  wire logic            reset_pin_disable,
   input  wire logic            sleep_instr,
   input  wire logic            wake_event,
   output logic [7:0]           rdata,
   output logic [7:0]           clock_gate,
   output logic                 sleeping,
   output logic [1:0]           sleep_mode,
   output logic                 bod_off,
   output logic                 comparator_ok,
   output logic                 core_reset,
   output logic                 port_reset
);
   spr_state_reg_type s_q;
   spr_state_reg_type s_d;
   logic              src_any;
   logic              hard_b;
   logic              core_rst_q;
   logic              port_rst_q;

   // Any source asserted; watchdog pulse counts as one cycle of assertion
   assign src_any = src.pwr_low | (~src.pin_low_b & ~reset_pin_disable)
                  | src.wdog_pulse | (src.bod_low & bod_enable);
   // Immediate sources clear everything without a clock
   assign hard_b = rst_b & ~src.pwr_low & ~(src.bod_low & bod_enable)
                 & ~(~src.pin_low_b & ~reset_pin_disable);

   // Read mux, unmapped and reserved bits read as zero
   function automatic logic [7:0] read_reg(input spr_state_reg_type st, input logic [1:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         ADDR_SLEEP_CONTROL: v = {5'h00, st.sleep_ctl};
         ADDR_CORE_CONTROL:  begin
            v[SLEEP_OFF_BIT] = st.off_set;
            v[UNLOCK_BIT]    = st.unlock;
         end
         ADDR_PERIPH_GATE:   v = st.gate & PERIPH_GATE_MASK;
         ADDR_RESET_STATUS:  v = {4'h0, st.cause};
      endcase
      return v;
   endfunction

   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.rdata = bus.rd ? read_reg(s_q, bus.addr) : 8'h00;
      if (src.wdog_pulse) begin
         s_d.cause[3] = 1'b1;
      end
      // Unlock window counts down four cycles
      if (s_q.unlock_cnt != 3'h0) begin
         s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;
      end else begin
         s_d.unlock = 1'b0;
      end
      // Sleep-off: three cycles to active, then held three cycles
      if (s_q.off_set) begin
         if (s_q.off_delay != 2'h0) begin
            s_d.off_delay = s_q.off_delay - 2'h1;
         end else begin
            s_d.off_active = 1'b1;
            s_d.off_hold   = SLEEP_OFF_HOLD;
         end
      end
      if (s_q.off_active) begin
         if (s_q.off_hold > 2'h1) begin
            s_d.off_hold = s_q.off_hold - 2'h1;
         end else begin
            s_d.off_active = 1'b0;
            s_d.off_set    = 1'b0;
         end
      end
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_SLEEP_CONTROL: s_d.sleep_ctl = bus.wdata[2:0];
            ADDR_CORE_CONTROL: begin
               if (bus.wdata[SLEEP_OFF_BIT] && bus.wdata[UNLOCK_BIT]) begin
                  s_d.unlock     = 1'b1;
                  s_d.unlock_cnt = UNLOCK_WINDOW - 3'h1;              // Next four cycles only
               end else if (bus.wdata[SLEEP_OFF_BIT] && s_q.unlock && !s_q.off_set) begin
                  s_d.off_set    = 1'b1;
                  s_d.off_delay  = SLEEP_OFF_DELAY - 2'h1;
                  s_d.unlock     = 1'b0;
                  s_d.unlock_cnt = 3'h0;
               end
            end
            ADDR_PERIPH_GATE:  s_d.gate = bus.wdata & PERIPH_GATE_MASK;
            ADDR_RESET_STATUS: s_d.cause = s_q.cause & bus.wdata[3:0];
         endcase
      end
      // Converter gated means comparator unusable
      s_d.comp_ok  = ~s_d.gate[GATE_CONVERTER_BIT];
      s_d.gate_out = s_d.gate;
      // Sleep sequencing
      unique case (s_q.state)
         ST_RUN: begin
            if (sleep_instr && s_q.sleep_ctl[SLEEP_ARM_BIT]
                && s_q.sleep_ctl[2:1] != MODE_RESERVED) begin
               s_d.state    = ST_SLEEP;
               s_d.sleeping = 1'b1;
               s_d.mode     = s_q.sleep_ctl[2:1];
               s_d.bod_off  = s_q.off_active && s_q.sleep_ctl[2:1] == MODE_POWER_DN;
            end
         end
         ST_SLEEP: begin
            if (wake_event) begin
               s_d.bod_off = 1'b0;
               if (s_q.bod_off) begin
                  s_d.state    = ST_WAKE;
                  s_d.tout_cnt = 16'(TIMEOUT);
               end else begin
                  s_d.state    = ST_RUN;
                  s_d.sleeping = 1'b0;
               end
            end
         end
         ST_WAKE: begin
            // Detector settles for a full reset delay before code resumes
            if (s_q.tout_cnt > 16'h0001) begin
               s_d.tout_cnt = s_q.tout_cnt - 16'h0001;
            end else begin
               s_d.state    = ST_RUN;
               s_d.sleeping = 1'b0;
            end
         end
      endcase
   end

   // Register stage; immediate sources act without a clock
   always_ff @(posedge clk_sys or negedge hard_b) begin
      if (!hard_b) begin
         s_q       <= '0;
         s_q.state <= ST_RUN;
         s_q.comp_ok <= 1'b1;
      end else if (src.wdog_pulse) begin
         s_q       <= '0;
         s_q.state <= ST_RUN;
         s_q.comp_ok <= 1'b1;
         s_q.cause <= s_q.cause | 4'h8;
      end else begin
         s_q <= s_d;
      end
   end

   // Reset stretch counter: reloads while any source holds
   logic [15:0] stretch_q;
   always_ff @(posedge clk_sys or negedge hard_b) begin
      if (!hard_b) begin
         stretch_q  <= 16'(TIMEOUT);
         core_rst_q <= 1'b1;
         port_rst_q <= 1'b1;
      end else if (src_any) begin
         stretch_q  <= 16'(TIMEOUT);
         core_rst_q <= 1'b1;
         port_rst_q <= 1'b1;
      end else if (stretch_q != 16'h0000) begin
         stretch_q  <= stretch_q - 16'h0001;
      end else begin
         core_rst_q <= 1'b0;
         port_rst_q <= 1'b0;
      end
   end

   assign rdata         = s_q.rdata;
   assign clock_gate    = s_q.gate_out;
   assign sleeping      = s_q.sleeping;
   assign sleep_mode    = s_q.mode;
   assign bod_off       = s_q.bod_off;
   assign comparator_ok = s_q.comp_ok;
   assign core_reset    = core_rst_q;
   assign port_reset    = port_rst_q;
endmodule

// ==== logic/spr_pkg.sv ====
/*
 * Constants, register layout and carrier types for the sleep, power and reset controller.
 * Assumes one 10 MHz system clock and a plain one-cycle register port.
 */
// Contract
// - Sleep control bits 7..3 read zero and ignore writes.
// - Sleep mode field bits 2..1: idle, noise reduction, power-down, reserved.
// - Sleep instruction sleeps only while sleep arm bit 0 is one.
// - Sleep-off bit 6 set only by unlock write then set write within four cycles.
// - Sleep-off becomes active three cycles after set, clears three cycles later.
// - Detector is off for a sleep only if sleep executes while sleep-off active.
// - Core control bit 7 and bits 3..0 read zero.
// - Unlock bit 5 gates setting of sleep-off; without it, no effect.
// - Gate bit stops peripheral clock, freezes it, blocks its register access.
// - Clearing gate bit restarts clock, peripheral resumes in held state.
// - Gate bits: 7 two-wire, 5 timer zero, 3 timer one, 2 serial, 0 converter.
// - Software disables converter before gating; comparator unusable while gated.
// - Reset forces all registers to initial values; run from reset vector after. Watchdog reset keeps the reset status bits and sets bit 3.
// - Port state resets asynchronously as soon as any source asserts; watchdog sets port reset only at the clock edge that samples its pulse.
// - Delay counter stretches internal reset after all sources release.
// - Exactly four reset sources: power-on, pin, watchdog, brown-out.
// - Power-on low reasserts reset at once; counter runs after release.
// - Long low pin resets without clock; delay after rise; pin may be disabled.
// - Enabled brown-out reset is immediate; delay follows after it clears.
// - Watchdog reset pulse is one cycle; delay starts on its falling edge.
// - Sleep-off turns detector off in power-down; wake delay equals reset delay.
package spr_pkg;
   localparam logic [1:0] ADDR_SLEEP_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_CORE_CONTROL  = 2'h1;
   localparam logic [1:0] ADDR_PERIPH_GATE   = 2'h2;
   localparam logic [1:0] ADDR_RESET_STATUS  = 2'h3;
   localparam int SLEEP_ARM_BIT    = 0;
   localparam int SLEEP_MODE_LSB   = 1;
   localparam int UNLOCK_BIT       = 5;
   localparam int SLEEP_OFF_BIT    = 6;
   localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h07;
   localparam logic [7:0] PERIPH_GATE_MASK   = 8'hAD;
   localparam int GATE_TWO_WIRE_BIT   = 7;
   localparam int GATE_TIMER_ZERO_BIT = 5;
   localparam int GATE_TIMER_ONE_BIT  = 3;
   localparam int GATE_SERIAL_BIT     = 2;
   localparam int GATE_CONVERTER_BIT  = 0;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam logic [2:0] UNLOCK_WINDOW   = 3'h4;
   localparam logic [1:0] SLEEP_OFF_DELAY = 2'h3;
   localparam logic [1:0] SLEEP_OFF_HOLD  = 2'h3;
   localparam logic [1:0] MODE_IDLE      = 2'h0;
   localparam logic [1:0] MODE_NOISE_RED = 2'h1;
   localparam logic [1:0] MODE_POWER_DN  = 2'h2;
   localparam logic [1:0] MODE_RESERVED  = 2'h3;
   localparam int TIMEOUT_US = 65;
   localparam int CLK_MHZ    = 10;
   localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE  = 3'b100
   } spr_state_type;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } spr_bus_type;

   typedef struct packed {
      logic pwr_low;
      logic pin_low_b;
      logic wdog_pulse;
      logic bod_low;
   } spr_rst_src_type;

   typedef struct packed {
      spr_state_type state;
      logic [2:0]    sleep_ctl;
      logic [7:0]    gate;
      logic          unlock;
      logic [2:0]    unlock_cnt;
      logic          off_set;
      logic [1:0]    off_delay;
      logic          off_active;
      logic [1:0]    off_hold;
      logic          bod_off;
      logic [1:0]    mode;
      logic [15:0]   tout_cnt;
      logic [7:0]    rdata;
      logic [7:0]    gate_out;
      logic          sleeping;
      logic          comp_ok;
      logic [3:0]    cause;
   } spr_state_reg_type;
endpackage

// ==== dv/spr_properties.sv ====
/* Checker for the sleep, power and reset controller, bound to spr_top.
   Assumes one clock and the bench's TIMEOUT of at least 8. */
`timescale 1ns/1ns
module spr_checker
   import spr_pkg::*;
#(
   parameter int TIMEOUT = 8
) (
   input wire logic            clk_sys,
   input wire logic            rst_b,
   input wire spr_bus_type     bus,
   input wire spr_rst_src_type src,
   input wire logic            bod_enable,
   input wire logic            reset_pin_disable,
   input wire logic [7:0]      rdata,
   input wire logic [7:0]      clock_gate,
   input wire logic            sleeping,
   input wire logic [1:0]      sleep_mode,
   input wire logic            bod_off,
   input wire logic            comparator_ok,
   input wire logic            core_reset,
   input wire logic            port_reset
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   chk_sleep_rsvd: assert property ($past(bus.rd) && $past(bus.addr) == ADDR_SLEEP_CONTROL
      |-> rdata[7:3] == 5'h00) else $error("sleep reserved bits set");
   chk_core_rsvd: assert property ($past(bus.rd) && $past(bus.addr) == ADDR_CORE_CONTROL
      |-> rdata[7] == 1'b0 && rdata[3:0] == 4'h0) else $error("core reserved set");
   chk_gate_rsvd: assert property ((clock_gate & ~PERIPH_GATE_MASK) == 8'h00)
      else $error("reserved gate bit set");
   chk_comp_gated: assert property (clock_gate[0] |-> !comparator_ok)
      else $error("comparator usable while gated");
   chk_mode_rsvd: assert property (sleeping |-> sleep_mode != MODE_RESERVED)
      else $error("slept in reserved mode");
   chk_bod_mode: assert property ($rose(bod_off) |-> sleeping && sleep_mode == MODE_POWER_DN)
      else $error("detector off outside power-down");
   chk_wdog_rst: assert property (src.wdog_pulse |=> core_reset && port_reset)
      else $error("watchdog pulse gave no reset");
   chk_pwr_rst: assert property (src.pwr_low |-> core_reset && port_reset)
      else $error("power-on low gave no reset");
   chk_bod_rst: assert property (bod_enable && src.bod_low |-> core_reset)
      else $error("brown-out gave no reset");
   chk_pin_rst: assert property (!reset_pin_disable && !src.pin_low_b |-> port_reset)
      else $error("pin low gave no port reset");
   chk_stretch: assert property ($fell(src.pwr_low) |-> core_reset [*8])
      else $error("reset released too early");
endmodule

bind spr_top spr_checker #(.TIMEOUT(TIMEOUT)) chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .bus(bus), .src(src), .bod_enable(bod_enable), .reset_pin_disable(reset_pin_disable),
   .rdata(rdata), .clock_gate(clock_gate), .sleeping(sleeping), .sleep_mode(sleep_mode),
   .bod_off(bod_off), .comparator_ok(comparator_ok), .core_reset(core_reset),
   .port_reset(port_reset));

// ==== dv/tb_spr_top.sv ====
/* Self-checking bench for spr_top: registers, sleep, sleep-off, gating, resets.
   Assumes the one-cycle register port and a shortened TIMEOUT of 8. */
`timescale 1ns/1ns
module tb_spr_top;
   import spr_pkg::*;
   localparam int TOUT = 8;
   logic            clk_sys, rst_b, bod_enable, reset_pin_disable, sleep_instr, wake_event;
   spr_bus_type     bus;
   spr_rst_src_type src;
   logic [7:0]      rdata, clock_gate;
   logic [1:0]      sleep_mode;
   logic            sleeping, bod_off, comparator_ok, core_reset, port_reset;
   int              checks, error_cnt;

   spr_top #(.TIMEOUT(TOUT)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .src(src),
      .bod_enable(bod_enable), .reset_pin_disable(reset_pin_disable),
      .sleep_instr(sleep_instr), .wake_event(wake_event), .rdata(rdata),
      .clock_gate(clock_gate), .sleeping(sleeping), .sleep_mode(sleep_mode),
      .bod_off(bod_off), .comparator_ok(comparator_ok), .core_reset(core_reset),
      .port_reset(port_reset));

   // 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // One-cycle pulse on the wake input or on the sleep instruction input
   task automatic pulse(input logic is_wake);
      @(posedge clk_sys);
      if (is_wake) wake_event <= 1'b1;
      else sleep_instr <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      sleep_instr <= 1'b0;
   endtask

   // Count edges until the stretched reset lets go
   task automatic stretch;
      int n;
      n = 0;
      while (core_reset === 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1 n++;
      end
      check(8'(n), 8'(TOUT + 1));
   endtask

   // Bounded wait for wake; slow wake only after a detector-off sleep
   task automatic wake(input logic slow);
      pulse(1'b1);
      repeat (3) @(posedge clk_sys);
      #1 if (slow) check({7'h00, sleeping}, 8'h01);
      for (int k = 0; k < 30 && sleeping !== 1'b0; k++) @(posedge clk_sys);
      #1 check({6'h00, bod_off, sleeping}, 8'h00);
      wr(ADDR_SLEEP_CONTROL, 8'h00);
   endtask

   task automatic sleepoff(input logic ul, input int gap, input int dly, input logic exp);
      wr(ADDR_SLEEP_CONTROL, {5'h00, MODE_POWER_DN, 1'b1});
      if (ul) wr(ADDR_CORE_CONTROL, 8'h60);
      repeat (gap) @(posedge clk_sys);
      wr(ADDR_CORE_CONTROL, 8'h40);
      repeat (dly) @(posedge clk_sys);
      pulse(1'b0);
      #1 check({7'h00, bod_off}, {7'h00, exp});
      wake(exp);
   endtask

   task automatic hit(input int i, input logic on);
      case (i)
         0: src.pwr_low <= on;
         1: src.pin_low_b <= !on;
         2: src.wdog_pulse <= on;
         default: src.bod_low <= on;
      endcase
   endtask

   // Hang guard, well beyond the expected run
   initial begin
      #1000000;
      error_cnt++;
      complete_run();
   end

   initial begin
      checks = 0;
      error_cnt = 0;
      rst_b = 1'b0;
      bus = '0;
      src = '{pwr_low: 1'b0, pin_low_b: 1'b1, wdog_pulse: 1'b0, bod_low: 1'b0};
      bod_enable = 1'b1;
      reset_pin_disable = 1'b0;
      sleep_instr = 1'b0;
      wake_event = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      stretch();
      for (int a = 0; a < 3; a++) rdc(2'(a), 8'h00);
      wr(ADDR_SLEEP_CONTROL, 8'hFF);
      rdc(ADDR_SLEEP_CONTROL, 8'h07);
      wr(ADDR_CORE_CONTROL, 8'h8F);
      rdc(ADDR_CORE_CONTROL, 8'h00);
      wr(ADDR_SLEEP_CONTROL, 8'h00);
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_PERIPH_GATE, 8'h01 << i);
         rdc(ADDR_PERIPH_GATE, (8'h01 << i) & PERIPH_GATE_MASK);
         check(clock_gate, (8'h01 << i) & PERIPH_GATE_MASK);
         check({7'h00, comparator_ok}, {7'h00, i != 0});
      end
      wr(ADDR_PERIPH_GATE, 8'h00); // ungate all; reinit is the peripherals' job
      #1 check(clock_gate, 8'h00);
      $display("gating test done");
      for (int m = 0; m < 4; m++) begin
         for (int a = 0; a < 2; a++) begin
            wr(ADDR_SLEEP_CONTROL, {5'h00, 2'(m), 1'(a)});
            pulse(1'b0);
            #1 check({7'h00, sleeping}, {7'h00, a == 1 && m != 3});
            if (a == 1 && m != 3) check({6'h00, sleep_mode}, 8'(m));
            wake(1'b0);
         end
      end
      $display("sleep mode test done");
      sleepoff(1'b1, 0, 2, 1'b1);
      sleepoff(1'b0, 0, 2, 1'b0);
      sleepoff(1'b1, 2, 2, 1'b1);
      sleepoff(1'b1, 3, 2, 1'b0);
      sleepoff(1'b1, 0, 8, 1'b0);
      $display("sleep-off test done");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_PERIPH_GATE, 8'h2D);
         @(posedge clk_sys);
         hit(i, 1'b1);
         #1 if (i != 2) check({7'h00, port_reset}, 8'h01);
         @(posedge clk_sys);
         hit(i, 1'b0);
         #1 check({6'h00, port_reset, core_reset}, 8'h03);
         stretch();
         rdc(ADDR_PERIPH_GATE, 8'h00);
         rdc(ADDR_RESET_STATUS, (i == 2) ? 8'h08 : 8'h00);
         wr(ADDR_RESET_STATUS, 8'h00);
         rdc(ADDR_RESET_STATUS, 8'h00);
      end
      @(posedge clk_sys);
      reset_pin_disable <= 1'b1;
      bod_enable <= 1'b0;
      hit(1, 1'b1);
      hit(3, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1 check({7'h00, core_reset}, 8'h00);
      @(posedge clk_sys);
      hit(1, 1'b0);
      hit(3, 1'b0);
      $display("reset test done");
      complete_run();
   end
endmodule
